// >>> design/ssub_buffers.sv
// Channel status and user bit buffers between host registers and S/PDIF framing.
// Assumes framing strobes one subframe per pulse, Z only on a Channel A subframe.
`timescale 1ns/1ps
`default_nettype none
module ssub_buffers #(
  parameter int unsigned GAP_ZEROS = ssub_pkg::IU_GAP
) (
  input wire logic i_clock, // 20 MHz system clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [ssub_pkg::BYTE_W-1:0] i_reg_addr, // Register address
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  input wire logic [ssub_pkg::BYTE_W-1:0] i_reg_wdata, // Write data
  output logic [ssub_pkg::BYTE_W-1:0] o_reg_rdata, // Read data, next cycle
  input wire logic i_rx_valid, // Received subframe strobe
  input wire logic i_rx_chan_b, // Received subframe is Channel B
  input wire logic i_rx_z, // Received subframe follows Z preamble
  input wire logic i_rx_cs, // Received status bit
  input wire logic i_rx_user, // Received user bit
  input wire logic i_tx_req, // Transmit subframe request
  input wire logic i_tx_chan_b, // Requested subframe is Channel B
  input wire logic i_tx_z, // Requested subframe carries Z preamble
  output logic o_tx_cs, // Status bit for requested subframe
  output logic o_tx_user, // User bit for requested subframe
  output logic o_irq // Interrupt request, active high
);
  import ssub_pkg::*;

  if (GAP_ZEROS < 1 || GAP_ZEROS > 14) begin : g_bad_gap
    $error("GAP_ZEROS must be 1 to 14");
  end

  // ----------------------------------------
  // Host registers and status
  // ----------------------------------------
  logic [7:0] rx_cfg_ff, tx_cfg_ff, mask_ff, stat_ff, rdata_ff, uba_ff;
  logic [7:0] nxt_rx_cfg, nxt_tx_cfg, nxt_mask, nxt_stat, nxt_rdata, nxt_uba;
  logic irq_ff, nxt_irq;
  logic [CS_BITS-1:0] tcs_a_ff, tcs_b_ff, nxt_tcs_a, nxt_tcs_b;
  logic [CS_BITS-1:0] rin_a_ff, rin_b_ff, rcs_a_ff, rcs_b_ff;
  logic [CS_BITS-1:0] nxt_rin_a, nxt_rin_b, nxt_rcs_a, nxt_rcs_b;
  logic [UB_BITS-1:0] rub1_ff, rub2_ff, tub1_ff, tub2_ff;
  logic [UB_BITS-1:0] nxt_rub1, nxt_rub2, nxt_tub1, nxt_tub2;
  logic [Q_BITS-1:0] qsh_ff, nxt_qsh;
  logic [Q_DATA_BITS-1:0] qbuf_ff, nxt_qbuf;
  logic set_csb, set_rub, set_tub, set_tfb, set_qcrc, tx_wr_ok;
  logic [7:0] k;

  always_comb begin
    nxt_rx_cfg = rx_cfg_ff;
    nxt_tx_cfg = tx_cfg_ff;
    nxt_mask = mask_ff;
    nxt_uba = uba_ff;
    nxt_rdata = rdata_ff;
    nxt_tcs_a = tcs_a_ff;
    nxt_tcs_b = tcs_b_ff;
    k = 8'h00;
    if (i_reg_wr) begin
      if (i_reg_addr == A_RX_CFG) nxt_rx_cfg = i_reg_wdata;
      if (i_reg_addr == A_TX_CFG) nxt_tx_cfg = i_reg_wdata;
      if (i_reg_addr == A_MASK) nxt_mask = i_reg_wdata;
      if (i_reg_addr == A_RX_UB_ADDR) nxt_uba = i_reg_wdata;
      if (i_reg_addr >= A_TX_CS && i_reg_addr < A_TX_CS + 8'(CS_BYTES)) begin
        k = i_reg_addr - A_TX_CS;
        if (tx_cfg_ff[TXC_SEL]) nxt_tcs_b[k*8 +: 8] = i_reg_wdata;
        else nxt_tcs_a[k*8 +: 8] = i_reg_wdata;
      end
    end
    if (i_reg_rd) begin
      nxt_rdata = 8'h00;
      if (i_reg_addr == A_RX_CFG) nxt_rdata = rx_cfg_ff;
      if (i_reg_addr == A_TX_CFG) nxt_rdata = tx_cfg_ff;
      if (i_reg_addr == A_STAT) nxt_rdata = stat_ff;
      if (i_reg_addr == A_MASK) nxt_rdata = mask_ff;
      if (i_reg_addr == A_RX_UB_ADDR) nxt_rdata = uba_ff;
      if (i_reg_addr == A_RX_UB_DATA) begin
        nxt_rdata = (uba_ff <= 8'(UB_BYTE_LAST_L)) ? rub2_ff[uba_ff*8 +: 8] : 8'h00;
        nxt_uba = uba_ff + 8'h01;
      end
      if (i_reg_addr >= A_Q && i_reg_addr < A_Q + 8'(Q_DATA_BITS / 8)) begin
        k = i_reg_addr - A_Q;
        nxt_rdata = qbuf_ff[Q_DATA_BITS-1-k*8 -: 8];
      end
      if (i_reg_addr >= A_RX_CS && i_reg_addr < A_RX_CS + 8'(CS_BYTES)) begin
        k = i_reg_addr - A_RX_CS;
        nxt_rdata = rx_cfg_ff[RXC_VIEW] ? rcs_b_ff[k*8 +: 8] : rcs_a_ff[k*8 +: 8];
      end
      if (i_reg_addr >= A_TX_CS && i_reg_addr < A_TX_CS + 8'(CS_BYTES)) begin
        k = i_reg_addr - A_TX_CS;
        nxt_rdata = tx_cfg_ff[TXC_SEL] ? tcs_b_ff[k*8 +: 8] : tcs_a_ff[k*8 +: 8];
      end
    end
    // Read clears, a same-cycle event still sets
    nxt_stat = (i_reg_rd && i_reg_addr == A_STAT) ? 8'h00 : stat_ff;
    nxt_stat[ST_CSB] = nxt_stat[ST_CSB] | set_csb;
    nxt_stat[ST_RUB] = nxt_stat[ST_RUB] | (set_rub & mask_ff[ST_RUB]);
    nxt_stat[ST_TUB] = nxt_stat[ST_TUB] | set_tub;
    nxt_stat[ST_TFB] = nxt_stat[ST_TFB] | set_tfb;
    nxt_stat[ST_QCRC] = nxt_stat[ST_QCRC] | set_qcrc;
    nxt_irq = |(nxt_stat & mask_ff);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_cfg_ff <= 8'h00;
      tx_cfg_ff <= 8'h00;
      mask_ff <= 8'h00;
      stat_ff <= 8'h00;
      rdata_ff <= 8'h00;
      uba_ff <= 8'h00;
      irq_ff <= 1'b0;
      tcs_a_ff <= '0;
      tcs_b_ff <= '0;
    end else begin
      rx_cfg_ff <= nxt_rx_cfg;
      tx_cfg_ff <= nxt_tx_cfg;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      rdata_ff <= nxt_rdata;
      uba_ff <= nxt_uba;
      irq_ff <= nxt_irq;
      tcs_a_ff <= nxt_tcs_a;
      tcs_b_ff <= nxt_tcs_b;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  logic [7:0] rfrm_ff, nxt_rfrm, ridx;
  logic rsync_ff, nxt_rsync;
  logic [9:0] rpos_ff, nxt_rpos;
  logic [6:0] iun_ff, nxt_iun, qn_ff, nxt_qn;
  logic [3:0] zc_ff, nxt_zc;
  logic [2:0] ic_ff, nxt_ic;
  logic [7:0] ish_ff, nxt_ish;
  logic [15:0] crc_ff, nxt_crc;
  ssub_iu_t iu_ff, nxt_iu;
  ssub_mode_t rmode;
  logic rsmall;

  always_comb begin
    nxt_rfrm = rfrm_ff;
    nxt_rsync = rsync_ff;
    nxt_rin_a = rin_a_ff;
    nxt_rin_b = rin_b_ff;
    nxt_rcs_a = rcs_a_ff;
    nxt_rcs_b = rcs_b_ff;
    nxt_rpos = rpos_ff;
    nxt_rub1 = rub1_ff;
    nxt_rub2 = rub2_ff;
    nxt_iun = iun_ff;
    nxt_qn = qn_ff;
    nxt_zc = zc_ff;
    nxt_ic = ic_ff;
    nxt_ish = ish_ff;
    nxt_crc = crc_ff;
    nxt_qsh = qsh_ff;
    nxt_qbuf = qbuf_ff;
    nxt_iu = iu_ff;
    set_csb = 1'b0;
    set_rub = 1'b0;
    set_qcrc = 1'b0;
    ridx = i_rx_z ? 8'h00 : (i_rx_chan_b ? rfrm_ff : rfrm_ff + 8'h01);
    rmode = ssub_mode_t'(rx_cfg_ff[RXC_MODE +: 2]);
    rsmall = !rx_cfg_ff[RXC_SIZE];
    // In IU mode, professional streams choose their own handling
    if (rmode == UB_IU && rcs_a_ff[CS_PRO]) begin
      case (rcs_a_ff[CS_UMODE +: 4])
        4'h4, 4'hC: rmode = UB_PLAIN;
        4'h8: begin
          rmode = UB_PLAIN;
          rsmall = 1'b1;
        end
        default: rmode = UB_OFF;
      endcase
    end else if (rmode == UB_Q) begin
      rmode = UB_OFF;
    end
    if (i_rx_valid && ridx <= FRM_LAST) begin
      nxt_rfrm = ridx;
      if (i_rx_z) nxt_rsync = 1'b1;
      if (i_rx_chan_b) nxt_rin_b[ridx] = i_rx_cs;
      else nxt_rin_a[ridx] = i_rx_cs;
      // Whole block on both channels copied at once
      if (rsync_ff && i_rx_chan_b && ridx == FRM_LAST) begin
        nxt_rcs_a = nxt_rin_a;
        nxt_rcs_b = nxt_rin_b;
        // Every block, or only on change of first five bytes
        set_csb = !rx_cfg_ff[RXC_COND] ||
                  (nxt_rin_a[CHANGE_BITS-1:0] != rcs_a_ff[CHANGE_BITS-1:0]) ||
                  (nxt_rin_b[CHANGE_BITS-1:0] != rcs_b_ff[CHANGE_BITS-1:0]);
      end
      if (rmode == UB_PLAIN) begin
        // Block restarts at Z; a long buffer spans two blocks
        if (i_rx_z && (rsmall || rpos_ff != UB_LAST_S + 10'h001)) nxt_rpos = 10'h000;
        nxt_rub1[nxt_rpos] = i_rx_user;
        // Second buffer updated when first fills
        if (nxt_rpos == (rsmall ? UB_LAST_S : UB_LAST_L)) begin
          nxt_rub2 = nxt_rub1;
          set_rub = 1'b1;
          nxt_rpos = 10'h000;
        end else begin
          nxt_rpos = nxt_rpos + 10'h001;
        end
      end else if (rmode == UB_IU) begin
        unique case (iu_ff)
          IU_HUNT: begin
            if (i_rx_user) begin
              nxt_iu = IU_BITS;
              nxt_ish = 8'h01;
              nxt_ic = 3'h1;
              nxt_zc = 4'h0;
            end else if (zc_ff <= 4'(GAP_ZEROS)) begin
              nxt_zc = zc_ff + 4'h1;
              // Long zero run closes the message
              if (zc_ff == 4'(GAP_ZEROS) && iun_ff != 7'h00) begin
                nxt_rub2 = rub1_ff;
                set_rub = 1'b1;
                nxt_iun = 7'h00;
              end
            end
          end
          IU_BITS: begin
            nxt_ish = {ish_ff[6:0], i_rx_user};
            nxt_ic = ic_ff + 3'h1;
            // Q bit follows the leading one
            if (ic_ff == 3'h1) begin
              nxt_qsh = {qsh_ff[Q_BITS-2:0], i_rx_user};
              if (qn_ff < 7'(Q_DATA_BITS)) begin
                nxt_crc = {crc_ff[14:0], 1'b0} ^
                          ((crc_ff[15] ^ i_rx_user) ? CRC_POLY : 16'h0000);
              end
              if (qn_ff == Q_LAST) begin
                nxt_qbuf = nxt_qsh[Q_BITS-1 -: Q_DATA_BITS];
                set_qcrc = (~crc_ff != nxt_qsh[Q_CRC_BITS-1:0]);
                nxt_qn = 7'h00;
                nxt_crc = 16'h0000;
              end else begin
                nxt_qn = qn_ff + 7'h01;
              end
            end
            if (ic_ff == 3'h7) begin
              nxt_iu = IU_HUNT;
              if (iun_ff <= IU_LAST) begin
                nxt_rub1[iun_ff*8 +: 8] = nxt_ish;
                nxt_iun = iun_ff + 7'h01;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rfrm_ff <= 8'h00;
      rsync_ff <= 1'b0;
      rin_a_ff <= '0;
      rin_b_ff <= '0;
      rcs_a_ff <= '0;
      rcs_b_ff <= '0;
      rpos_ff <= 10'h000;
      rub1_ff <= '0;
      rub2_ff <= '0;
      iun_ff <= 7'h00;
      qn_ff <= 7'h00;
      zc_ff <= 4'h0;
      ic_ff <= 3'h0;
      ish_ff <= 8'h00;
      crc_ff <= 16'h0000;
      qsh_ff <= '0;
      qbuf_ff <= '0;
      iu_ff <= IU_HUNT;
    end else begin
      rfrm_ff <= nxt_rfrm;
      rsync_ff <= nxt_rsync;
      rin_a_ff <= nxt_rin_a;
      rin_b_ff <= nxt_rin_b;
      rcs_a_ff <= nxt_rcs_a;
      rcs_b_ff <= nxt_rcs_b;
      rpos_ff <= nxt_rpos;
      rub1_ff <= nxt_rub1;
      rub2_ff <= nxt_rub2;
      iun_ff <= nxt_iun;
      qn_ff <= nxt_qn;
      zc_ff <= nxt_zc;
      ic_ff <= nxt_ic;
      ish_ff <= nxt_ish;
      crc_ff <= nxt_crc;
      qsh_ff <= nxt_qsh;
      qbuf_ff <= nxt_qbuf;
      iu_ff <= nxt_iu;
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic [CS_BITS-1:0] act_a_ff, act_b_ff, nxt_act_a, nxt_act_b;
  logic [7:0] tfrm_ff, nxt_tfrm, tidx;
  logic [9:0] tpos_ff, nxt_tpos, tlast;
  logic [6:0] twp_ff, nxt_twp;
  logic tfull_ff, nxt_tfull, trun_ff, nxt_trun, tcs_ff, nxt_tcs, tub_ff, nxt_tub;
  ssub_mode_t tmode;

  always_comb begin
    nxt_act_a = act_a_ff;
    nxt_act_b = act_b_ff;
    nxt_tfrm = tfrm_ff;
    nxt_tpos = tpos_ff;
    nxt_twp = twp_ff;
    nxt_tfull = tfull_ff;
    nxt_trun = trun_ff;
    nxt_tcs = tcs_ff;
    nxt_tub = tub_ff;
    nxt_tub1 = tub1_ff;
    nxt_tub2 = tub2_ff;
    set_tub = 1'b0;
    set_tfb = 1'b0;
    tmode = ssub_mode_t'(tx_cfg_ff[TXC_MODE +: 2]);
    tlast = tx_cfg_ff[TXC_SIZE] ? UB_LAST_L : UB_LAST_S;
    tidx = i_tx_z ? 8'h00 : (i_tx_chan_b ? tfrm_ff : tfrm_ff + 8'h01);
    // Host fill; writes ignored once full
    tx_wr_ok = i_reg_wr && i_reg_addr == A_TX_UB_DATA && tmode != UB_OFF && !tfull_ff;
    if (tx_wr_ok) begin
      nxt_tub1[twp_ff*8 +: 8] = i_reg_wdata;
      nxt_twp = twp_ff + 7'h01;
      if (twp_ff == (tx_cfg_ff[TXC_SIZE] ? UB_BYTE_LAST_L : UB_BYTE_LAST_S)) begin
        nxt_tfull = 1'b1;
        set_tfb = 1'b1;
      end
    end
    if (i_tx_req && tidx <= FRM_LAST) begin
      nxt_tfrm = tidx;
      // Copy at block start unless inhibited
      if (i_tx_z && !tx_cfg_ff[TXC_INHIBIT]) begin
        nxt_act_a = tcs_a_ff;
        nxt_act_b = tx_cfg_ff[TXC_SAME] ? tcs_a_ff : tcs_b_ff;
      end
      nxt_tcs = i_tx_chan_b ? nxt_act_b[tidx] : nxt_act_a[tidx];
      nxt_tub = 1'b0;
      if (tmode == UB_OFF) begin
        nxt_trun = 1'b0;
      end else if (trun_ff) begin
        nxt_tub = tub2_ff[tpos_ff];
        nxt_tpos = tpos_ff + 10'h001;
        if (tpos_ff == tlast) nxt_trun = 1'b0;
      end
      // Plain mode may wait for Z
      if (tmode != UB_OFF && tfull_ff && (!trun_ff || tpos_ff == tlast) &&
          (i_tx_z || !tx_cfg_ff[TXC_ALIGN] || tmode != UB_PLAIN)) begin
        // Updated flag when buffer moves on
        nxt_tub2 = tub1_ff;
        nxt_tub = trun_ff ? tub2_ff[tpos_ff] : tub1_ff[0];
        nxt_tpos = trun_ff ? 10'h000 : 10'h001;
        nxt_trun = 1'b1;
        nxt_tfull = 1'b0;
        nxt_twp = 7'h00;
        set_tub = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_a_ff <= '0;
      act_b_ff <= '0;
      tfrm_ff <= 8'h00;
      tpos_ff <= 10'h000;
      twp_ff <= 7'h00;
      tfull_ff <= 1'b0;
      trun_ff <= 1'b0;
      tcs_ff <= 1'b0;
      tub_ff <= 1'b0;
      tub1_ff <= '0;
      tub2_ff <= '0;
    end else begin
      act_a_ff <= nxt_act_a;
      act_b_ff <= nxt_act_b;
      tfrm_ff <= nxt_tfrm;
      tpos_ff <= nxt_tpos;
      twp_ff <= nxt_twp;
      tfull_ff <= nxt_tfull;
      trun_ff <= nxt_trun;
      tcs_ff <= nxt_tcs;
      tub_ff <= nxt_tub;
      tub1_ff <= nxt_tub1;
      tub2_ff <= nxt_tub2;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_tx_cs = tcs_ff;
  assign o_tx_user = tub_ff;
  assign o_irq = irq_ff;
endmodule : ssub_buffers
`default_nettype wire

// >>> design/ssub_pkg.sv
// Constants, field positions and modes for the S/PDIF status and user bit buffers.
// Assumes a byte-wide host register port and one system clock.
package ssub_pkg;
  localparam int BYTE_W = 8;
  localparam int CS_BITS = 192;
  localparam int CS_BYTES = 24;
  localparam int UB_BITS = 768;
  localparam int IU_GAP = 8;
  localparam int Q_BITS = 96;
  localparam int Q_DATA_BITS = 80;
  localparam int Q_CRC_BITS = 16;
  localparam int CHANGE_BITS = 40;
  localparam logic [7:0] FRM_LAST = 8'hBF;
  localparam logic [9:0] UB_LAST_S = 10'h17F;
  localparam logic [9:0] UB_LAST_L = 10'h2FF;
  localparam logic [6:0] UB_BYTE_LAST_S = 7'h2F;
  localparam logic [6:0] UB_BYTE_LAST_L = 7'h5F;
  localparam logic [6:0] IU_LAST = 7'h5F;
  localparam logic [6:0] Q_LAST = 7'h5F;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // Register map
  localparam logic [7:0] A_RX_CFG = 8'h00;
  localparam logic [7:0] A_TX_CFG = 8'h01;
  localparam logic [7:0] A_STAT = 8'h02;
  localparam logic [7:0] A_MASK = 8'h03;
  localparam logic [7:0] A_RX_UB_ADDR = 8'h04;
  localparam logic [7:0] A_RX_UB_DATA = 8'h05;
  localparam logic [7:0] A_TX_UB_DATA = 8'h06;
  localparam logic [7:0] A_Q = 8'h08;
  localparam logic [7:0] A_RX_CS = 8'h20;
  localparam logic [7:0] A_TX_CS = 8'h38;
  // Receive configuration fields
  localparam int RXC_SIZE = 0;
  localparam int RXC_MODE = 1;
  localparam int RXC_COND = 3;
  localparam int RXC_VIEW = 7;
  // Transmit configuration fields
  localparam int TXC_SIZE = 0;
  localparam int TXC_MODE = 1;
  localparam int TXC_ALIGN = 3;
  localparam int TXC_SEL = 4;
  localparam int TXC_SAME = 5;
  localparam int TXC_INHIBIT = 6;
  // Status and mask bits, then channel status field positions
  localparam int ST_CSB = 0;
  localparam int ST_RUB = 1;
  localparam int ST_TUB = 2;
  localparam int ST_TFB = 3;
  localparam int ST_QCRC = 4;
  localparam int CS_PRO = 0;
  localparam int CS_UMODE = 12;
  typedef enum logic [1:0] {UB_OFF = 2'h0, UB_PLAIN = 2'h1, UB_IU = 2'h2, UB_Q = 2'h3} ssub_mode_t;
  typedef enum logic [1:0] {IU_HUNT = 2'b01, IU_BITS = 2'b10} ssub_iu_t;
endpackage : ssub_pkg

// >>> verif/ssub_buffers_asserts.sv
// Port-level checker for the status and user bit buffers.
// Assumes it is bound to ssub_buffers and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ssub_buffers_asserts #(
  parameter int unsigned GAP_ZEROS = 8
) (
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic [ssub_pkg::BYTE_W-1:0] i_reg_addr, // Register address
  input wire logic i_reg_wr, // Write strobe
  input wire logic i_reg_rd, // Read strobe
  input wire logic [ssub_pkg::BYTE_W-1:0] i_reg_wdata, // Write data
  input wire logic [ssub_pkg::BYTE_W-1:0] o_reg_rdata, // Read data
  input wire logic i_tx_req, // Transmit request
  input wire logic o_tx_cs, // Transmit status bit
  input wire logic o_tx_user, // Transmit user bit
  input wire logic o_irq // Interrupt request
);
  import ssub_pkg::*;
  logic [7:0] mask_ff, nxt_mask;
  logic [1:0] txm_ff, nxt_txm;
  logic wr_mask, rd_stat;
  assign wr_mask = i_reg_wr && (i_reg_addr == A_MASK);
  assign rd_stat = i_reg_rd && (i_reg_addr == A_STAT);
  // Shadow of the mask and transmit mode, as the host wrote them
  always_comb begin
    nxt_mask = wr_mask ? i_reg_wdata : mask_ff;
    nxt_txm = (i_reg_wr && i_reg_addr == A_TX_CFG) ? i_reg_wdata[2:1] : txm_ff;
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_ff <= 8'h00;
      txm_ff <= 2'h0;
    end else begin
      mask_ff <= nxt_mask;
      txm_ff <= nxt_txm;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  rdata_hold_a: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property ((i_reg_rd && i_reg_addr == 8'h07) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  mask_readback_a: assert property (rd_stat == 1'b0 && i_reg_rd && i_reg_addr == A_MASK
    |=> o_reg_rdata[4:0] == $past(mask_ff[4:0])) else $error("mask read mismatch");
  irq_masked_off_a: assert property (mask_ff[4:0] == 5'h00 |=> !o_irq)
    else $error("interrupt high with all masks clear");
  irq_rise_mask_a: assert property ($rose(o_irq) |-> (mask_ff[4:0] | $past(mask_ff[4:0])) != 5'h00)
    else $error("interrupt rose without a mask bit");
  irq_sticky_a: assert property ($fell(o_irq)
    |-> $past(rd_stat) || $past(rd_stat, 2) || $past(wr_mask) || $past(wr_mask, 2))
    else $error("interrupt fell without status read");
  tx_hold_a: assert property (!$past(i_tx_req) |-> $stable(o_tx_cs) && $stable(o_tx_user))
    else $error("transmit bits moved without request");
  tx_zero_user_a: assert property (i_tx_req && txm_ff == 2'h0 && $past(txm_ff) == 2'h0
    |=> !o_tx_user) else $error("user bit sent in zero mode");
endmodule : ssub_buffers_asserts
bind ssub_buffers ssub_buffers_asserts #(.GAP_ZEROS(GAP_ZEROS)) u_chk (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_tx_req(i_tx_req),
  .o_tx_cs(o_tx_cs), .o_tx_user(o_tx_user), .o_irq(o_irq));
`default_nettype wire

// >>> verif/ssub_link_model.sv
// Behavioural framing partner: sends received subframes, requests transmit
// subframes and gathers the returned bits. Assumes one subframe per two cycles.
`timescale 1ns/1ps
`default_nettype none
module ssub_link_model (
  input wire logic i_clock, // System clock
  output logic o_rx_valid, // Received subframe strobe
  output logic o_rx_chan_b, // Received subframe is B
  output logic o_rx_z, // Received Z preamble
  output logic o_rx_cs, // Received status bit
  output logic o_rx_user, // Received user bit
  output logic o_tx_req, // Transmit subframe request
  output logic o_tx_chan_b, // Requested subframe is B
  output logic o_tx_z, // Requested Z preamble
  input wire logic i_tx_cs, // Returned status bit
  input wire logic i_tx_user // Returned user bit
);
  initial begin
    {o_rx_valid, o_rx_chan_b, o_rx_z, o_rx_cs, o_rx_user} = 5'h00;
    {o_tx_req, o_tx_chan_b, o_tx_z} = 3'h0;
  end
  // every block opens with Z on Channel A
  task automatic send_block(input logic [191:0] a, input logic [191:0] b,
    input logic [383:0] u);
    for (int p = 0; p < 384; p++) begin
      @(negedge i_clock);
      o_rx_valid = 1'b1;
      o_rx_chan_b = p[0];
      o_rx_z = (p == 0);
      o_rx_cs = p[0] ? b[p/2] : a[p/2];
      o_rx_user = u[p];
      @(negedge i_clock);
      o_rx_valid = 1'b0;
      o_rx_z = 1'b0;
      // Released lines show the inverse, never the stale value
      o_rx_chan_b = ~o_rx_chan_b;
      o_rx_cs = ~o_rx_cs;
      o_rx_user = ~o_rx_user;
    end
  endtask : send_block
  // one full block of requests, bits taken the cycle after each
  task automatic tx_block(output logic [191:0] a, output logic [191:0] b,
    output logic [383:0] u);
    for (int p = 0; p < 384; p++) begin
      @(negedge i_clock);
      o_tx_req = 1'b1;
      o_tx_chan_b = p[0];
      o_tx_z = (p == 0);
      @(negedge i_clock);
      o_tx_req = 1'b0;
      o_tx_z = 1'b0;
      if (p[0]) b[p/2] = i_tx_cs;
      else a[p/2] = i_tx_cs;
      u[p] = i_tx_user;
    end
  endtask : tx_block
endmodule : ssub_link_model
`default_nettype wire

// >>> verif/ssub_buffers_test.sv
// Self-checking bench for the status and user bit buffers.
// Assumes the framing partner model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module ssub_buffers_test;
  import ssub_pkg::*;
  logic clock, rst_n, wr, rd, irq;
  logic [7:0] addr, wdata, rdata, v;
  logic rx_valid, rx_chan_b, rx_z, rx_cs, rx_user, tx_req, tx_chan_b, tx_z, tx_cs, tx_user;
  logic [191:0] pa, pb, ca, cb;
  logic [383:0] pu, cu;
  int err_count = 0;
  int comparisons = 0;
  always #25 clock = ~clock;
  ssub_buffers i_dut (.i_clock(clock), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rx_valid(rx_valid),
    .i_rx_chan_b(rx_chan_b), .i_rx_z(rx_z), .i_rx_cs(rx_cs), .i_rx_user(rx_user),
    .i_tx_req(tx_req), .i_tx_chan_b(tx_chan_b), .i_tx_z(tx_z), .o_tx_cs(tx_cs),
    .o_tx_user(tx_user), .o_irq(irq));
  ssub_link_model i_link (.i_clock(clock), .o_rx_valid(rx_valid), .o_rx_chan_b(rx_chan_b),
    .o_rx_z(rx_z), .o_rx_cs(rx_cs), .o_rx_user(rx_user), .o_tx_req(tx_req),
    .o_tx_chan_b(tx_chan_b), .o_tx_z(tx_z), .i_tx_cs(tx_cs), .i_tx_user(tx_user));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clock);
    addr = a;
    rd = 1'b1;
    @(negedge clock);
    rd = 1'b0;
    v = rdata;
  endtask : rd_reg
  task automatic cmp_cs(input logic [191:0] ea, input logic [191:0] eb);
    for (int k = 0; k < 24; k++) begin
      check(ca[8*k+:8], ea[8*k+:8]);
      check(cb[8*k+:8], eb[8*k+:8]);
    end
  endtask : cmp_cs
  task automatic rx_status_block;
    wr_reg(A_MASK, 8'h03);
    wr_reg(A_RX_CFG, 8'h02);
    i_link.send_block(pa, pb, pu);
    repeat (2) @(negedge clock);
    check({7'h00, irq}, 8'h01);
    rd_reg(A_STAT);
    check(v, 8'h03);
    repeat (2) @(negedge clock);
    check({7'h00, irq}, 8'h00);
    for (int k = 0; k < 24; k++) begin
      rd_reg(A_RX_CS + 8'(k));
      check(v, pa[8*k+:8]);
    end
    wr_reg(A_RX_CFG, 8'h82);
    for (int k = 0; k < 24; k++) begin
      rd_reg(A_RX_CS + 8'(k));
      check(v, pb[8*k+:8]);
    end
    rd_reg(8'h07);
    check(v, 8'h00);
    rd_reg(A_MASK);
    check(v, 8'h03);
    wr_reg(A_RX_UB_ADDR, 8'h00);
    for (int k = 0; k < 48; k++) begin
      rd_reg(A_RX_UB_DATA);
      check(v, pu[8*k+:8]);
    end
  endtask : rx_status_block
  task automatic rx_change_flag;
    wr_reg(A_RX_CFG, 8'h08);
    i_link.send_block(pa, pb, pu);
    rd_reg(A_STAT);
    check(v, 8'h00);
    pa[7:0] = ~pa[7:0];
    i_link.send_block(pa, pb, pu);
    rd_reg(A_STAT);
    check(v, 8'h01);
  endtask : rx_change_flag
  task automatic tx_status_block;
    wr_reg(A_MASK, 8'h00);
    wr_reg(A_TX_CFG, 8'h40);
    for (int k = 0; k < 24; k++) wr_reg(A_TX_CS + 8'(k), pa[8*k+:8]);
    wr_reg(A_TX_CFG, 8'h50);
    for (int k = 0; k < 24; k++) wr_reg(A_TX_CS + 8'(k), pb[8*k+:8]);
    wr_reg(A_TX_CFG, 8'h00);
    i_link.tx_block(ca, cb, cu);
    cmp_cs(pa, pb);
    // inhibit keeps the old block going out
    wr_reg(A_TX_CFG, 8'h40);
    wr_reg(A_TX_CS, ~pa[7:0]);
    i_link.tx_block(ca, cb, cu);
    cmp_cs(pa, pb);
    pa[7:0] = ~pa[7:0];
    wr_reg(A_TX_CFG, 8'h20);
    i_link.tx_block(ca, cb, cu);
    cmp_cs(pa, pa);
  endtask : tx_status_block
  task automatic tx_user_flags;
    wr_reg(A_MASK, 8'h04);
    wr_reg(A_TX_CFG, 8'h02);
    for (int k = 0; k < 48; k++) wr_reg(A_TX_UB_DATA, pu[8*k+:8]);
    // Write past full must be dropped
    wr_reg(A_TX_UB_DATA, 8'hFF);
    check({7'h00, irq}, 8'h00);
    rd_reg(A_STAT);
    check(v, 8'h08);
    i_link.tx_block(ca, cb, cu);
    for (int k = 0; k < 48; k++) check(cu[8*k+:8], pu[8*k+:8]);
    check({7'h00, irq}, 8'h01);
    rd_reg(A_STAT);
    check(v, 8'h04);
  endtask : tx_user_flags
  task automatic rx_user_modes;
    wr_reg(A_MASK, 8'h02);
    wr_reg(A_RX_CFG, 8'h04);
    pa[0] = 1'b0;
    i_link.send_block(pa, pb, 384'h0);
    // Two IUs, two stuffed zeros between, then a long zero run
    i_link.send_block(pa, pb, 384'h30CA5);
    rd_reg(A_STAT);
    check(v, 8'h03);
    wr_reg(A_RX_UB_ADDR, 8'h00);
    rd_reg(A_RX_UB_DATA);
    check(v, 8'hA5);
    rd_reg(A_RX_UB_DATA);
    check(v, 8'hC3);
    // Long buffer must span two blocks
    wr_reg(A_RX_CFG, 8'h03);
    i_link.send_block(pa, pb, pu);
    rd_reg(A_STAT);
    check(v, 8'h01);
    i_link.send_block(pa, pb, ~pu);
    rd_reg(A_STAT);
    check(v, 8'h03);
    wr_reg(A_RX_UB_ADDR, 8'h2F);
    rd_reg(A_RX_UB_DATA);
    check(v, pu[383:376]);
    rd_reg(A_RX_UB_DATA);
    check(v, ~pu[7:0]);
  endtask : rx_user_modes
  task automatic conclude;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    {clock, rst_n, wr, rd} = 4'h0;
    {addr, wdata} = 16'h0000;
    for (int k = 0; k < 48; k++) pu[8*k+:8] = 8'(k) * 8'h1D ^ 8'h96;
    pa = pu[191:0] ^ {24{8'h5A}};
    pb = pu[383:192];
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    rx_status_block();
    rx_change_flag();
    tx_status_block();
    tx_user_flags();
    rx_user_modes();
    conclude();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    conclude();
  end
endmodule : ssub_buffers_test
`default_nettype wire
